// File: fbmc_top.sv
// Framebuffer memory configuration and command interface
`timescale 1ns/10ps
module fbmc_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Configuration
  input wire fbmc_pkg::fbmc_mem_type CFG_MEM_TYPE,
  input wire logic [1:0] CFG_SIZE,
  input wire logic CFG_WIDTH,
  input wire logic CFG_LOAD,
  // Configuration status
  output logic CFG_VALID,
  output logic CFG_ERROR,
  output logic [3:0] CFG_DEVICES,
  output logic CFG_SDRAM,
  output logic CFG_WIDE,
  // Access requests
  input wire logic [2:0] REQ_OP,
  input wire logic REQ_BANK,
  input wire logic REQ_EXT_BANK,
  input wire logic REQ_ALL_BANKS,
  input wire logic [10:0] REQ_ADDR,
  input wire logic [15:0] REQ_BYTE_EN,
  input wire logic [127:0] REQ_WDATA,
  output logic REQ_READY,
  output logic REQ_REJECT,
  // Memory pins
  output logic PRIMARY_CHIP_SELECT_N,
  output logic SECONDARY_CHIP_SELECT,
  output logic ROW_STROBE_N,
  output logic COLUMN_STROBE_N,
  output logic WRITE_STROBE_N,
  output logic [10:0] MEMORY_ADDRESS_BUS,
  output logic [15:0] BYTE_MASK,
  input wire logic [127:0] MEMORY_DATA_BUS_IN,
  output logic [127:0] MEMORY_DATA_BUS_OUT,
  output logic MEMORY_DATA_BUS_OE,
  // Read return
  output logic [127:0] RD_DATA,
  output logic RD_VALID
);

  // ==========================================================================
  // Configuration latch
  typedef enum logic [1:0] {
    FBMC_UNCONF,
    FBMC_READY,
    FBMC_BAD
  } fbmc_cfg_state_type;

  fbmc_cfg_state_type cfg_state_q, cfg_state_d;
  fbmc_pkg::fbmc_mem_type type_q, type_d;
  logic [1:0] size_q, size_d;
  logic width_q, width_d;
  logic [3:0] devs_q, devs_d;
  logic chk_ok;
  logic [3:0] chk_devs;

  fbmc_cfg_check u_check (
    .mem_type(CFG_MEM_TYPE),
    .size_code(CFG_SIZE),
    .width_code(CFG_WIDTH),
    .supported(chk_ok),
    .device_count(chk_devs)
  );

  // A load is accepted in any cycle, even with an access in flight, so the map
  // can change under an open row
  always_comb begin
    cfg_state_d = cfg_state_q;
    type_d = type_q;
    size_d = size_q;
    width_d = width_q;
    devs_d = devs_q;
    if (CFG_LOAD) begin
      if (chk_ok) begin
        cfg_state_d = FBMC_READY;
        type_d = CFG_MEM_TYPE;
        size_d = CFG_SIZE;
        width_d = CFG_WIDTH;
        devs_d = chk_devs;
      end else begin
        cfg_state_d = FBMC_BAD;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg_state_q <= FBMC_UNCONF;
      type_q <= fbmc_pkg::FBMC_SGRAM8_2B;
      size_q <= fbmc_pkg::SIZE_2MB;
      width_q <= fbmc_pkg::WIDTH_64;
      devs_q <= 4'h0;
    end else begin
      cfg_state_q <= cfg_state_d;
      type_q <= type_d;
      size_q <= size_d;
      width_q <= width_d;
      devs_q <= devs_d;
    end
  end

  logic sdram_mode;
  logic cfg_ready;
  assign sdram_mode = (type_q == fbmc_pkg::FBMC_SDRAM16);
  assign cfg_ready = (cfg_state_q == FBMC_READY);
  assign CFG_VALID = cfg_ready;
  assign CFG_ERROR = (cfg_state_q == FBMC_BAD);
  assign CFG_DEVICES = devs_q;
  assign CFG_SDRAM = sdram_mode & cfg_ready;
  assign CFG_WIDE = width_q; // Sizes never exceed 8 MByte

  // ==========================================================================
  // Command issue: one command per cycle, burst length one
  logic [3:0] cmd_d, cmd_q;
  logic cs2_d, cs2_q;
  logic [10:0] addr_d, addr_q;
  logic [15:0] wmask_d;
  logic [127:0] wdata_d, wdata_q;
  logic oe_d, oe_q;
  logic op_legal;
  logic narrow;

  assign narrow = (width_q == fbmc_pkg::WIDTH_64);
  assign REQ_READY = cfg_ready;
  assign op_legal = (REQ_OP <= fbmc_pkg::OP_LOAD_MODE);
  assign REQ_REJECT = (REQ_OP != fbmc_pkg::OP_NONE) &
                      (~cfg_ready | ~op_legal);

  always_comb begin
    cmd_d = fbmc_pkg::CMD_NOP;
    cs2_d = 1'b1;
    addr_d = REQ_ADDR;
    wmask_d = fbmc_pkg::MASK_RESET;
    wdata_d = wdata_q;
    oe_d = 1'b0;
    if (!cfg_ready) begin
      cmd_d = fbmc_pkg::CMD_INHIBIT;
    end else begin
      // SGRAM: secondary select picks external bank 2 when 8 parts
      if (!sdram_mode) begin
        cs2_d = ~(REQ_EXT_BANK & (devs_q == fbmc_pkg::DEV_8));
      end else begin
        cs2_d = REQ_BANK;
      end
      unique case (REQ_OP)
        fbmc_pkg::OP_ACTIVE: begin
          cmd_d = fbmc_pkg::CMD_ACTIVE;
          // SDRAM row uses all eleven lines including A10
          if (!sdram_mode) begin
            addr_d[10] = REQ_BANK;
          end
        end
        fbmc_pkg::OP_READ, fbmc_pkg::OP_WRITE: begin
          cmd_d = (REQ_OP == fbmc_pkg::OP_READ) ?
                  fbmc_pkg::CMD_READ : fbmc_pkg::CMD_WRITE;
          if (sdram_mode) begin
            addr_d[10] = 1'b0;
          end else begin
            addr_d[10] = REQ_BANK;
            addr_d[9] = 1'b0;
          end
          if (REQ_OP == fbmc_pkg::OP_WRITE) begin
            wdata_d = REQ_WDATA;
            oe_d = 1'b1;
            wmask_d = ~REQ_BYTE_EN; // Zero delay on writes
          end
        end
        fbmc_pkg::OP_PRECHARGE: begin
          cmd_d = fbmc_pkg::CMD_PRECHARGE;
          if (sdram_mode) begin
            addr_d[10] = REQ_ALL_BANKS;
          end else begin
            addr_d[9] = REQ_ALL_BANKS;
            addr_d[10] = REQ_BANK;
          end
        end
        fbmc_pkg::OP_LOAD_MODE: begin
          cmd_d = fbmc_pkg::CMD_LOAD_MODE;
          if (sdram_mode) begin
            cs2_d = REQ_EXT_BANK;
          end
        end
        default: begin
          cmd_d = fbmc_pkg::CMD_NOP;
        end
      endcase
    end
    // Upper lanes unpopulated on a 64-bit bus stay masked
    if (narrow) begin
      wmask_d[15:8] = 8'hFF;
    end
  end

  // ==========================================================================
  // Read mask pipeline: mask trails the read command by two clocks
  logic [15:0] rmask_pipe_q [fbmc_pkg::READ_MASK_DELAY];
  logic [15:0] rmask_pipe_d [fbmc_pkg::READ_MASK_DELAY];
  logic [fbmc_pkg::READ_MASK_DELAY-1:0] rd_pipe_q, rd_pipe_d;
  logic is_read;

  assign is_read = cfg_ready & (REQ_OP == fbmc_pkg::OP_READ);

  always_comb begin
    rmask_pipe_d[0] = is_read ? ~REQ_BYTE_EN : fbmc_pkg::MASK_RESET;
    rd_pipe_d[0] = is_read;
    for (int i = 1; i < fbmc_pkg::READ_MASK_DELAY; i++) begin
      rmask_pipe_d[i] = rmask_pipe_q[i-1];
      rd_pipe_d[i] = rd_pipe_q[i-1];
    end
  end

  // Mask leaves the pipe so it meets the data two clocks after the read
  logic [15:0] mask_out_d;
  always_comb begin
    mask_out_d = wmask_d & rmask_pipe_q[fbmc_pkg::READ_MASK_DELAY-1];
    if (narrow) begin
      mask_out_d[15:8] = 8'hFF;
    end
  end

  logic [15:0] mask_q;
  logic [127:0] rdata_q;
  logic rvalid_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cmd_q <= fbmc_pkg::CMD_INHIBIT;
      cs2_q <= 1'b1;
      addr_q <= fbmc_pkg::ADDR_RESET;
      wdata_q <= '0;
      oe_q <= 1'b0;
      mask_q <= fbmc_pkg::MASK_RESET;
      rd_pipe_q <= '0;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      for (int i = 0; i < fbmc_pkg::READ_MASK_DELAY; i++) begin
        rmask_pipe_q[i] <= fbmc_pkg::MASK_RESET;
      end
    end else begin
      cmd_q <= cmd_d;
      cs2_q <= cs2_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      oe_q <= oe_d;
      mask_q <= mask_out_d;
      rd_pipe_q <= rd_pipe_d;
      rvalid_q <= rd_pipe_q[fbmc_pkg::READ_MASK_DELAY-1];
      if (rd_pipe_q[fbmc_pkg::READ_MASK_DELAY-1]) begin
        rdata_q <= narrow ? {64'h0, MEMORY_DATA_BUS_IN[63:0]} :
                   MEMORY_DATA_BUS_IN;
      end
      for (int i = 0; i < fbmc_pkg::READ_MASK_DELAY; i++) begin
        rmask_pipe_q[i] <= rmask_pipe_d[i];
      end
    end
  end

  // Pin drive, all from flops
  assign PRIMARY_CHIP_SELECT_N = cmd_q[3];
  assign ROW_STROBE_N = cmd_q[2];
  assign COLUMN_STROBE_N = cmd_q[1];
  assign WRITE_STROBE_N = cmd_q[0];
  assign SECONDARY_CHIP_SELECT = cs2_q;
  assign MEMORY_ADDRESS_BUS = addr_q;
  assign BYTE_MASK = mask_q;
  assign MEMORY_DATA_BUS_OUT = wdata_q;
  assign MEMORY_DATA_BUS_OE = oe_q;
  assign RD_DATA = rdata_q;
  assign RD_VALID = rvalid_q;

endmodule

// File: fbmc_pkg.sv
// Package of constants and types for the framebuffer memory configuration
package fbmc_pkg;

  // ==========================================================================
  // Configuration encodings
  typedef enum logic [1:0] {
    FBMC_SGRAM8_2B,
    FBMC_SGRAM16_2B,
    FBMC_SGRAM16_4B,
    FBMC_SDRAM16
  } fbmc_mem_type;

  // Total size codes
  localparam logic [1:0] SIZE_2MB = 2'h0;
  localparam logic [1:0] SIZE_4MB = 2'h1;
  localparam logic [1:0] SIZE_8MB = 2'h2;

  // Width codes
  localparam logic WIDTH_64 = 1'h0;
  localparam logic WIDTH_128 = 1'h1;

  // Device counts per arrangement
  localparam logic [3:0] DEV_2 = 4'h2;
  localparam logic [3:0] DEV_4 = 4'h4;
  localparam logic [3:0] DEV_8 = 4'h8;

  // ==========================================================================
  // Command encodings: {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_INHIBIT = 4'hF;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;

  // Request opcodes on the user side
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_ACTIVE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_PRECHARGE = 3'h4;
  localparam logic [2:0] OP_LOAD_MODE = 3'h5;

  // ==========================================================================
  // Widths and reset values
  localparam int DATA_W = 128;
  localparam int MASK_W = 16;
  localparam int ADDR_W = 11;
  localparam int READ_MASK_DELAY = 2;
  localparam logic [MASK_W-1:0] MASK_RESET = 16'hFFFF;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 11'h000;
  localparam logic [1:0] HALF_MASK_DIS = 2'h2;

endpackage

// File: fbmc_cfg_check.sv
// Checker of supported framebuffer memory arrangements
`timescale 1ns/10ps
module fbmc_cfg_check (
  // Requested arrangement
  input wire fbmc_pkg::fbmc_mem_type mem_type,
  input wire logic [1:0] size_code,
  input wire logic width_code,
  // Verdict
  output logic supported,
  output logic [3:0] device_count
);

  // Only the table's arrangements pass; everything else is refused
  always_comb begin
    supported = 1'b0;
    device_count = 4'h0;
    unique case (mem_type)
      fbmc_pkg::FBMC_SGRAM8_2B: begin
        // 8 Mbit parts allow 2, 4 and 8 MByte
        if (size_code == fbmc_pkg::SIZE_2MB &&
            width_code == fbmc_pkg::WIDTH_64) begin
          supported = 1'b1;
          device_count = fbmc_pkg::DEV_2;
        end else if (size_code == fbmc_pkg::SIZE_4MB &&
                     width_code == fbmc_pkg::WIDTH_128) begin
          supported = 1'b1;
          device_count = fbmc_pkg::DEV_4;
        end else if (size_code == fbmc_pkg::SIZE_8MB &&
                     width_code == fbmc_pkg::WIDTH_128) begin
          supported = 1'b1;
          device_count = fbmc_pkg::DEV_8;
        end
      end
      fbmc_pkg::FBMC_SGRAM16_2B, fbmc_pkg::FBMC_SGRAM16_4B: begin
        // 16 Mbit parts have no 2 MByte option
        if (size_code == fbmc_pkg::SIZE_4MB &&
            width_code == fbmc_pkg::WIDTH_64) begin
          supported = 1'b1;
          device_count = fbmc_pkg::DEV_2;
        end else if (size_code == fbmc_pkg::SIZE_8MB &&
                     width_code == fbmc_pkg::WIDTH_128) begin
          supported = 1'b1;
          device_count = fbmc_pkg::DEV_4;
        end
      end
      fbmc_pkg::FBMC_SDRAM16: begin
        // SDRAM: only four parts, 8 MByte, 64 bits
        if (size_code == fbmc_pkg::SIZE_8MB &&
            width_code == fbmc_pkg::WIDTH_64) begin
          supported = 1'b1;
          device_count = fbmc_pkg::DEV_4;
        end
      end
    endcase
  end

endmodule

// File: fbmc_checker.sv
// Concurrent checks on the ports of the framebuffer configuration block
`timescale 1ns/10ps
module fbmc_checker (
  // Clock, reset and configuration
  input wire logic CLK,
  input wire logic RST,
  input wire fbmc_pkg::fbmc_mem_type CFG_MEM_TYPE,
  input wire logic [1:0] CFG_SIZE,
  input wire logic CFG_WIDTH,
  input wire logic CFG_LOAD,
  input wire logic CFG_VALID,
  input wire logic CFG_ERROR,
  input wire logic [3:0] CFG_DEVICES,
  input wire logic CFG_SDRAM,
  // Requests
  input wire logic [2:0] REQ_OP,
  input wire logic REQ_BANK,
  input wire logic REQ_ALL_BANKS,
  input wire logic [10:0] REQ_ADDR,
  input wire logic [15:0] REQ_BYTE_EN,
  // Memory pins and read return
  input wire logic PRIMARY_CHIP_SELECT_N,
  input wire logic SECONDARY_CHIP_SELECT,
  input wire logic ROW_STROBE_N,
  input wire logic COLUMN_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic [10:0] MEMORY_ADDRESS_BUS,
  input wire logic [15:0] BYTE_MASK,
  input wire logic MEMORY_DATA_BUS_OE,
  input wire logic RD_VALID
);
  logic [3:0] cmd;
  logic sd_load;
  logic sd_req;
  // ==========================================================================
  // Command word and qualifiers
  assign cmd = {PRIMARY_CHIP_SELECT_N, ROW_STROBE_N, COLUMN_STROBE_N,
    WRITE_STROBE_N};
  assign sd_load = CFG_LOAD && CFG_MEM_TYPE == fbmc_pkg::FBMC_SDRAM16;
  assign sd_req = CFG_VALID && CFG_SDRAM;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ==========================================================================
  // Configuration
  a_sdram_ok: assert property (sd_load && !CFG_WIDTH &&
    CFG_SIZE == 2'h2 |=> CFG_VALID && CFG_DEVICES == 4'h4)
    else $error("SDRAM 8MB arrangement refused");
  a_sdram_wide: assert property (sd_load && CFG_WIDTH |=>
    CFG_ERROR && !CFG_VALID) else $error("wide SDRAM accepted");
  a_sgram16_2mb: assert property (CFG_LOAD && CFG_SIZE == 2'h0 &&
    CFG_MEM_TYPE inside {fbmc_pkg::FBMC_SGRAM16_2B,
    fbmc_pkg::FBMC_SGRAM16_4B} |=> CFG_ERROR)
    else $error("2MB of 16Mbit SGRAM accepted");
  // ==========================================================================
  // Commands; the read mask waits two clocks behind its command
  a_read_cmd: assert property (CFG_VALID && REQ_OP == 3'h2 |=>
    cmd == 4'h5 ##2 RD_VALID) else $error("read command or return wrong");
  a_write_mask: assert property (CFG_VALID && REQ_OP == 3'h3 |=>
    cmd == 4'h4 && MEMORY_DATA_BUS_OE &&
    BYTE_MASK[7:0] == ~$past(REQ_BYTE_EN[7:0])) else $error("write wrong");
  a_read_mask: assert property (CFG_VALID && REQ_OP == 3'h2 ##2
    REQ_OP != 3'h3 |=> BYTE_MASK[7:0] == ~$past(REQ_BYTE_EN[7:0], 3))
    else $error("read mask not two clocks late");
  a_sdram_pre: assert property (sd_req && REQ_OP == 3'h4 |=>
    MEMORY_ADDRESS_BUS[10] == $past(REQ_ALL_BANKS) &&
    SECONDARY_CHIP_SELECT == $past(REQ_BANK)) else $error("precharge wrong");
  a_sdram_act: assert property (sd_req && REQ_OP == 3'h1 |=>
    MEMORY_ADDRESS_BUS == $past(REQ_ADDR) &&
    SECONDARY_CHIP_SELECT == $past(REQ_BANK)) else $error("active wrong");
endmodule

bind fbmc_top fbmc_checker u_chk (.CLK, .RST, .CFG_MEM_TYPE, .CFG_SIZE,
  .CFG_WIDTH, .CFG_LOAD, .CFG_VALID, .CFG_ERROR, .CFG_DEVICES, .CFG_SDRAM,
  .REQ_OP, .REQ_BANK, .REQ_ALL_BANKS, .REQ_ADDR, .REQ_BYTE_EN,
  .PRIMARY_CHIP_SELECT_N, .SECONDARY_CHIP_SELECT, .ROW_STROBE_N,
  .COLUMN_STROBE_N, .WRITE_STROBE_N, .MEMORY_ADDRESS_BUS, .BYTE_MASK,
  .MEMORY_DATA_BUS_OE, .RD_VALID);

// File: fbmc_mem_model.sv
// Behavioural SDRAM or SGRAM array on the far side of the memory pins
`timescale 1ns/10ps
module fbmc_mem_model (
  // Clock and mode
  input wire logic clk,
  input wire logic sdram_mode,
  // Command pins
  input wire logic cs_n,
  input wire logic cs2,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [10:0] addr,
  input wire logic [15:0] dqm,
  input wire logic [127:0] dq_in,
  // Data back to the controller
  output logic [127:0] dq_out
);
  logic [127:0] mem [int];
  logic [10:0] row [2];
  logic bank;
  int key;
  initial dq_out = 128'h0;
  // ==========================================================================
  // Commands sampled on the rising edge; an idle bus toggles, never stale
  always @(posedge clk) begin
    bank = sdram_mode ? cs2 : addr[10];
    key = {bank, row[bank], addr[7:0]};
    if (!cs_n && {ras_n, cas_n, we_n} == 3'h3)
      row[bank] = sdram_mode ? addr : {1'b0, addr[9:0]};
    if (!cs_n && {ras_n, cas_n, we_n} == 3'h4) begin
      if (!mem.exists(key))
        mem[key] = 128'h0;
      for (int b = 0; b < 16; b++)
        if (!dqm[b])
          mem[key][8*b+:8] = dq_in[8*b+:8];
    end
    if (!cs_n && {ras_n, cas_n, we_n} == 3'h5 && mem.exists(key))
      dq_out <= mem[key];
    else
      dq_out <= ~dq_out;
  end
endmodule

// File: framebuffer_memory_config_bench.sv
// Self-checking bench for the framebuffer memory configuration block
`timescale 1ns/10ps
module framebuffer_memory_config_bench;
  logic CLK = 0, RST = 1, CFG_WIDTH = 0, CFG_LOAD = 0, REQ_BANK = 0;
  logic REQ_ALL_BANKS = 0, REQ_EXT_BANK = 0;
  logic CFG_VALID, CFG_ERROR, CFG_SDRAM, CFG_WIDE, REQ_REJECT, RD_VALID;
  logic PRIMARY_CHIP_SELECT_N, SECONDARY_CHIP_SELECT, ROW_STROBE_N;
  logic COLUMN_STROBE_N, WRITE_STROBE_N, MEMORY_DATA_BUS_OE, REQ_READY;
  fbmc_pkg::fbmc_mem_type CFG_MEM_TYPE = fbmc_pkg::FBMC_SGRAM8_2B;
  logic [1:0] CFG_SIZE = 2'h0;
  logic [2:0] REQ_OP = 3'h0;
  logic [3:0] CFG_DEVICES, cmd;
  logic [10:0] REQ_ADDR = 11'h000, MEMORY_ADDRESS_BUS;
  logic [15:0] REQ_BYTE_EN = 16'h0000, BYTE_MASK;
  logic [127:0] REQ_WDATA = 128'h0, din, MEMORY_DATA_BUS_OUT, RD_DATA;
  logic [127:0] exp_mem [4];
  logic [127:0] exp_q [$];
  logic [15:0] exp_mk [$];
  logic [3:0] codes [8] = '{4'h7, 4'h3, 4'h5, 4'h4, 4'h2, 4'h0, 4'h7, 4'h7};
  int miscompares = 0, n_compared = 0, t_idx;
  assign cmd = {PRIMARY_CHIP_SELECT_N, ROW_STROBE_N, COLUMN_STROBE_N,
    WRITE_STROBE_N};
  always #12.5 CLK = ~CLK;
  // ==========================================================================
  // Design and memory model
  fbmc_top DUT (.CLK, .RST, .CFG_MEM_TYPE, .CFG_SIZE, .CFG_WIDTH, .CFG_LOAD,
    .CFG_VALID, .CFG_ERROR, .CFG_DEVICES, .CFG_SDRAM, .CFG_WIDE, .REQ_OP,
    .REQ_BANK, .REQ_EXT_BANK, .REQ_ALL_BANKS, .REQ_ADDR, .REQ_BYTE_EN,
    .REQ_WDATA, .REQ_READY, .REQ_REJECT, .PRIMARY_CHIP_SELECT_N,
    .SECONDARY_CHIP_SELECT, .ROW_STROBE_N, .COLUMN_STROBE_N, .WRITE_STROBE_N,
    .MEMORY_ADDRESS_BUS, .BYTE_MASK, .MEMORY_DATA_BUS_IN(din),
    .MEMORY_DATA_BUS_OUT, .MEMORY_DATA_BUS_OE, .RD_DATA, .RD_VALID);
  fbmc_mem_model u_mem (.clk(CLK), .sdram_mode(CFG_SDRAM),
    .cs_n(PRIMARY_CHIP_SELECT_N), .cs2(SECONDARY_CHIP_SELECT),
    .ras_n(ROW_STROBE_N), .cas_n(COLUMN_STROBE_N), .we_n(WRITE_STROBE_N),
    .addr(MEMORY_ADDRESS_BUS), .dqm(BYTE_MASK), .dq_in(MEMORY_DATA_BUS_OUT),
    .dq_out(din));
  // ==========================================================================
  // Comparison, verdict and reference arrangement table
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Device count of a legal arrangement, zero when refused
  function automatic int devs(input int t, input int s, input int w);
    case (t * 8 + s * 2 + w)
      0, 10, 18: return 2;
      3, 13, 21, 28: return 4;
      5: return 8;
      default: return 0;
    endcase
  endfunction
  // ==========================================================================
  // Drivers: all inputs change on the falling edge
  task automatic load(input int t, input int s, input int w);
    int d;
    d = devs(t, s, w);
    CFG_MEM_TYPE = fbmc_pkg::fbmc_mem_type'(t[1:0]);
    CFG_SIZE = s[1:0];
    CFG_WIDTH = w[0];
    CFG_LOAD = 1'b1;
    @(negedge CLK);
    CFG_LOAD = 1'b0;
    check(CFG_VALID, d != 0);
    check(CFG_ERROR, d == 0);
    if (d != 0) check({CFG_SDRAM, CFG_WIDE, CFG_DEVICES}, {t == 3, w[0], d[3:0]});
    check(REQ_READY, d != 0);
    // Idle cycle so the next load never re-raises the strobe at once
    @(negedge CLK);
  endtask
  // One request per call, so calls in a row are back to back
  task automatic issue(input logic [2:0] op, input logic [10:0] a,
    input logic [1:0] ab, input logic [15:0] be);
    logic [127:0] wd;
    logic ok;
    logic x;
    logic sel;
    wd = {$urandom, $urandom, $urandom, $urandom};
    x = 1'($urandom);
    ok = CFG_VALID && op <= 3'h5;
    REQ_OP = op;
    REQ_ADDR = a;
    {REQ_ALL_BANKS, REQ_BANK} = ab;
    REQ_BYTE_EN = be;
    REQ_WDATA = wd;
    REQ_EXT_BANK = x;
    #1;
    check(REQ_REJECT, op != 3'h0 && !ok);
    if (ok && op == 3'h3)
      for (int b = 0; b < 16; b++)
        if (be[b] && (CFG_WIDE || b < 8))
          exp_mem[a[1:0]][8*b+:8] = wd[8*b+:8];
    if (ok && op == 3'h2) begin
      exp_q.push_back(CFG_WIDE ? exp_mem[a[1:0]] : exp_mem[a[1:0]][63:0]);
      exp_mk.push_back(~be | (CFG_WIDE ? 16'h0000 : 16'hFF00));
    end
    // Second external bank is only selectable with eight SGRAM parts
    sel = CFG_SDRAM ? ab[0] : !(x && CFG_DEVICES == 4'h8);
    @(negedge CLK);
    check(cmd, CFG_VALID ? codes[op] : 4'hF);
    if (ok && op == 3'h3) check({MEMORY_DATA_BUS_OE, BYTE_MASK}, {1'b1, ~be | (CFG_WIDE ? 16'h0 : 16'hFF00)});
    if (ok && op == 3'h4 && !CFG_SDRAM) check(MEMORY_ADDRESS_BUS[10:9], {ab[0], ab[1]});
    if (ok && op == 3'h4 && CFG_SDRAM) check({MEMORY_ADDRESS_BUS[10], SECONDARY_CHIP_SELECT}, ab);
    if (ok && op == 3'h1) check(SECONDARY_CHIP_SELECT, sel);
  endtask
  // Activate, eight writes, four reads, then every remaining opcode
  task automatic traffic(input int t, input int s, input int w);
    load(t, s, w);
    issue(3'h1, 11'h0A5, 2'h0, 16'h0);
    for (int i = 0; i < 8; i++)
      issue(3'h3, 11'(i % 4), 2'h0, i < 4 ? 16'hFFFF : 16'($urandom));
    for (int i = 0; i < 4; i++)
      issue(3'h2, 11'(i), 2'h0, 16'($urandom));
    for (int i = 0; i < 8; i++)
      issue(i < 4 ? 3'h4 : 3'(i + 1), 11'h155, 2'(i), 16'h0);
  endtask
  // Every returned read is compared in order with the reference
  // The read's lane mask stands in the same cycle as its returned data
  always @(negedge CLK)
    if (RD_VALID === 1'b1) begin
      check(RD_DATA, exp_q.pop_front());
      check(BYTE_MASK, exp_mk.pop_front());
    end
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(17));
    repeat (6) @(posedge CLK);
    @(negedge CLK);
    RST = 1'b0;
    issue(3'h2, 11'h000, 2'h0, 16'h0);
    issue(3'h0, 11'h000, 2'h0, 16'h0);
    for (t_idx = 0; t_idx < 32; t_idx++)
      load(t_idx / 8, t_idx / 2 % 4, t_idx % 2);
    traffic(3, 2, 0);
    traffic(1, 1, 0);
    traffic(2, 2, 1);
    traffic(0, 2, 1);
    check(exp_q.size(), 0);
    give_verdict();
  end
  // Watchdog: the run needs about 165 cycles, so 1000 means a hang
  initial begin
    #(25 * 1000);
    miscompares++;
    give_verdict();
  end
endmodule
